/* File: design/lsp_params.svh */
`ifndef LSP_PARAMS_SVH
`define LSP_PARAMS_SVH
// address map
`define LSP_ADDR_W        17
`define LSP_MEM_LAST      17'h13fff
`define LSP_REG_FIRST     17'h1ffe0
`define LSP_REG_LAST      17'h1ffff
`define LSP_ALIAS_STEP    17
`define LSP_ALIAS_COUNT   512
// straps
`define LSP_BUS_GENERIC   3'h7
`define LSP_CNF_ENDIAN    3
// timing: host wait for release, cycles
`define LSP_HOST_TIMEOUT  16'h0400
// setup spans the device's two-flop select sync plus its hold-off register,
// so the host's first wait sample already sees hold-off asserted
`define LSP_HOST_SETUP    3
`endif

/* File: design/lsp_pkg.sv */
package lsp_pkg;
  typedef enum logic [1:0] {
    LSP_TGT_NONE = 2'h0,
    LSP_TGT_MEM  = 2'h1,
    LSP_TGT_REG  = 2'h3
  } lsp_target_t;
  typedef enum logic [2:0] {
    LSP_DS_IDLE = 3'h0,
    LSP_DS_ARB  = 3'h1,
    LSP_DS_DONE = 3'h3,
    LSP_DS_END  = 3'h2
  } lsp_dev_state_t;
  typedef enum logic [2:0] {
    LSP_HS_IDLE  = 3'h0,
    LSP_HS_SETUP = 3'h1,
    LSP_HS_WAIT  = 3'h3,
    LSP_HS_END   = 3'h2,
    LSP_HS_GAP   = 3'h6
  } lsp_host_state_t;
endpackage

/* File: design/lsp_bus_if.sv */
`timescale 1ns/10ps
interface lsp_bus_if;
  logic [16:0] address_in;
  logic [15:0] data_host;
  logic [15:0] data_dev;
  logic        data_dev_oe;
  logic        chip_select_n;
  logic        read_strobe_n;
  logic        write_strobe_n;
  logic        high_byte_enable_n;
  logic        rd_wr_dir;
  logic        hold_off_n;
  logic        bus_status_strap;
  logic [3:0]  config_straps;
  modport device (
    input  address_in, data_host, chip_select_n, read_strobe_n, write_strobe_n,
           high_byte_enable_n, rd_wr_dir, bus_status_strap, config_straps,
    output data_dev, data_dev_oe, hold_off_n
  );
  modport host (
    output address_in, data_host, chip_select_n, read_strobe_n, write_strobe_n,
           high_byte_enable_n, rd_wr_dir, bus_status_strap, config_straps,
    input  data_dev, data_dev_oe, hold_off_n
  );
endinterface

/* File: design/lsp_device.sv */
`timescale 1ns/10ps
`include "lsp_params.svh"
module lsp_device #(
  parameter int ADDR_W = `LSP_ADDR_W
) (
  input  wire logic        host_bus_clock,
  input  wire logic        reset_n,
  lsp_bus_if.device        bus,
  output logic             core_req_q,
  output logic             core_we_q,
  output lsp_pkg::lsp_target_t core_target_q,
  output logic [ADDR_W-1:0] core_addr_q,
  output logic [15:0]      core_wdata_q,
  output logic [1:0]       core_be_q,
  input  wire logic        core_grant,
  input  wire logic [15:0] core_rdata,
  output logic             big_endian_q,
  output logic             shared_enable_mode_q,
  output logic             generic_mode_q,
  output logic             cfg_valid_q
);
  import lsp_pkg::*;

  // ===========================================
  // synchronisers
  logic [2:0] sync1_q, sync2_q;
  logic [2:0] sync1_d;
  always_comb begin
    sync1_d = {~bus.chip_select_n, ~bus.read_strobe_n, ~bus.write_strobe_n};
  end
  always_ff @(posedge host_bus_clock or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync1_q;
    end
  end
  logic sel_s, rd_s, wr_s;
  assign sel_s = sync2_q[2];
  assign rd_s  = sync2_q[1];
  assign wr_s  = sync2_q[0];

  // ===========================================
  // strap capture
  logic       cfg_taken_q, cfg_taken_d;
  logic       big_endian_d, shared_d, generic_d;
  always_comb begin
    cfg_taken_d  = 1'b1;
    big_endian_d = big_endian_q;
    shared_d     = shared_enable_mode_q;
    generic_d    = generic_mode_q;
    if (!cfg_taken_q) begin
      big_endian_d = bus.config_straps[`LSP_CNF_ENDIAN];
      generic_d    = (bus.config_straps[2:0] == `LSP_BUS_GENERIC);
      shared_d     = bus.bus_status_strap;
    end
  end
  always_ff @(posedge host_bus_clock or negedge reset_n) begin
    if (!reset_n) begin
      cfg_taken_q          <= 1'b0;
      big_endian_q         <= 1'b0;
      shared_enable_mode_q <= 1'b0;
      generic_mode_q       <= 1'b0;
      cfg_valid_q          <= 1'b0;
    end else begin
      cfg_taken_q          <= cfg_taken_d;
      big_endian_q         <= big_endian_d;
      shared_enable_mode_q <= shared_d;
      generic_mode_q       <= generic_d;
      cfg_valid_q          <= cfg_taken_q;
    end
  end

  // ===========================================
  // address decode
  lsp_target_t tgt;
  always_comb begin
    tgt = LSP_TGT_NONE;
    if (bus.address_in <= `LSP_MEM_LAST) begin
      tgt = LSP_TGT_MEM;
    end else if (bus.address_in >= `LSP_REG_FIRST) begin
      tgt = LSP_TGT_REG;
    end
  end

  // ===========================================
  // access sequencer
  lsp_dev_state_t state_q, state_d;
  logic        hold_n_q, hold_n_d;
  logic        oe_q, oe_d;
  logic [15:0] rdata_q, rdata_d;
  logic        req_d, we_d;
  lsp_target_t tgt_d;
  logic [ADDR_W-1:0] addr_d;
  logic [15:0] wdata_d;
  logic [1:0]  be_d;
  logic        active;
  // rd/wr direction pin deliberately unused in shared mode
  assign active = cfg_valid_q && generic_mode_q && shared_enable_mode_q && sel_s;
  always_comb begin
    state_d = state_q;
    hold_n_d = hold_n_q;
    oe_d    = oe_q && sel_s && rd_s;
    rdata_d = rdata_q;
    req_d   = core_req_q;
    we_d    = core_we_q;
    tgt_d   = core_target_q;
    addr_d  = core_addr_q;
    wdata_d = core_wdata_q;
    be_d    = core_be_q;
    case (state_q)
      LSP_DS_IDLE: begin
        hold_n_d = 1'b1;
        if (active && (rd_s || wr_s)) begin
          hold_n_d = 1'b0;
          req_d    = (tgt != LSP_TGT_NONE);
          we_d     = wr_s;
          tgt_d    = tgt;
          addr_d   = bus.address_in;
          be_d     = {~bus.high_byte_enable_n, 1'b1};
          wdata_d  = big_endian_q ? {bus.data_host[7:0], bus.data_host[15:8]} : bus.data_host;
          state_d  = (tgt != LSP_TGT_NONE) ? LSP_DS_ARB : LSP_DS_DONE;
          if (tgt == LSP_TGT_NONE) begin
            rdata_d = 16'h0000;
          end
        end
      end
      LSP_DS_ARB: begin
        if (core_grant) begin
          req_d   = 1'b0;
          rdata_d = big_endian_q ? {core_rdata[7:0], core_rdata[15:8]} : core_rdata;
          state_d = LSP_DS_DONE;
        end
      end
      LSP_DS_DONE: begin
        hold_n_d = 1'b1;
        oe_d     = !core_we_q && sel_s && rd_s;
        state_d  = LSP_DS_END;
      end
      LSP_DS_END: begin
        if (!(sel_s && (rd_s || wr_s))) begin
          state_d = LSP_DS_IDLE;
        end
      end
      default: begin
        state_d = LSP_DS_IDLE;
      end
    endcase
  end
  always_ff @(posedge host_bus_clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q       <= LSP_DS_IDLE;
      hold_n_q      <= 1'b1;
      oe_q          <= 1'b0;
      rdata_q       <= 16'h0000;
      core_req_q    <= 1'b0;
      core_we_q     <= 1'b0;
      core_target_q <= LSP_TGT_NONE;
      core_addr_q   <= '0;
      core_wdata_q  <= 16'h0000;
      core_be_q     <= 2'h0;
    end else begin
      state_q       <= state_d;
      hold_n_q      <= hold_n_d;
      oe_q          <= oe_d;
      rdata_q       <= rdata_d;
      core_req_q    <= req_d;
      core_we_q     <= we_d;
      core_target_q <= tgt_d;
      core_addr_q   <= addr_d;
      core_wdata_q  <= wdata_d;
      core_be_q     <= be_d;
    end
  end

  assign bus.hold_off_n  = hold_n_q;
  assign bus.data_dev_oe = oe_q;
  // upper byte only when high enable held
  assign bus.data_dev    = {core_be_q[1] ? rdata_q[15:8] : 8'h00, rdata_q[7:0]};
endmodule

/* File: design/lsp_host.sv */
`timescale 1ns/10ps
`include "lsp_params.svh"
module lsp_host #(
  parameter int        ADDR_W  = `LSP_ADDR_W,
  parameter logic [15:0] TIMEOUT = `LSP_HOST_TIMEOUT
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  lsp_bus_if.host          bus,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_high_byte,
  input  wire logic [25:0] req_addr,
  input  wire logic [15:0] req_wdata,
  input  wire logic        big_endian_strap,
  output logic             req_ready_q,
  output logic             rsp_valid_q,
  output logic [15:0]      rsp_rdata_q,
  output logic             rsp_timeout_q,
  output logic             card_side_disable_q
);
  import lsp_pkg::*;

  // ===========================================
  // host cycle sequencer
  lsp_host_state_t state_q, state_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [15:0] wdata_q, wdata_d, rdata_d;
  logic        cs_n_q, cs_n_d, rd_n_q, rd_n_d, wr_n_q, wr_n_d, hbe_n_q, hbe_n_d;
  logic        rdy_d, vld_d, tmo_d, dis_d;
  logic [15:0] cnt_q, cnt_d;
  logic        hold_n_s_q;
  always_comb begin
    state_d = state_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    rdata_d = rsp_rdata_q;
    cs_n_d  = cs_n_q;
    rd_n_d  = rd_n_q;
    wr_n_d  = wr_n_q;
    hbe_n_d = hbe_n_q;
    rdy_d   = 1'b0;
    vld_d   = 1'b0;
    tmo_d   = rsp_timeout_q;
    dis_d   = card_side_disable_q;
    cnt_d   = cnt_q + 16'h0001;
    case (state_q)
      LSP_HS_IDLE: begin
        rdy_d = 1'b1;
        if (req_valid && req_ready_q) begin
          rdy_d   = 1'b0;
          // upper lines dropped, so the device aliases each 128K
          addr_d  = req_addr[ADDR_W-1:0];
          wdata_d = req_wdata;
          cs_n_d  = 1'b0;
          dis_d   = 1'b1;
          hbe_n_d = ~req_high_byte;
          rd_n_d  = req_write;
          wr_n_d  = ~req_write;
          tmo_d   = 1'b0;
          cnt_d   = 16'h0000;
          state_d = LSP_HS_SETUP;
        end
      end
      LSP_HS_SETUP: begin
        if (cnt_q >= 16'(`LSP_HOST_SETUP)) begin
          cnt_d   = 16'h0000;
          state_d = LSP_HS_WAIT;
        end
      end
      LSP_HS_WAIT: begin
        if (hold_n_s_q || cnt_q >= TIMEOUT) begin
          tmo_d   = !hold_n_s_q;
          rdata_d = bus.data_dev;
          state_d = LSP_HS_END;
        end
      end
      LSP_HS_END: begin
        cs_n_d  = 1'b1;
        rd_n_d  = 1'b1;
        wr_n_d  = 1'b1;
        hbe_n_d = 1'b1;
        vld_d   = 1'b1;
        cnt_d   = 16'h0000;
        state_d = LSP_HS_GAP;
      end
      LSP_HS_GAP: begin
        dis_d = 1'b0;
        if (cnt_q >= 16'(`LSP_HOST_SETUP)) begin
          state_d = LSP_HS_IDLE;
        end
      end
      default: begin
        state_d = LSP_HS_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q             <= LSP_HS_IDLE;
      addr_q              <= '0;
      wdata_q             <= 16'h0000;
      rsp_rdata_q         <= 16'h0000;
      cs_n_q              <= 1'b1;
      rd_n_q              <= 1'b1;
      wr_n_q              <= 1'b1;
      hbe_n_q             <= 1'b1;
      req_ready_q         <= 1'b0;
      rsp_valid_q         <= 1'b0;
      rsp_timeout_q       <= 1'b0;
      card_side_disable_q <= 1'b0;
      cnt_q               <= 16'h0000;
      hold_n_s_q          <= 1'b1;
    end else begin
      state_q             <= state_d;
      addr_q              <= addr_d;
      wdata_q             <= wdata_d;
      rsp_rdata_q         <= rdata_d;
      cs_n_q              <= cs_n_d;
      rd_n_q              <= rd_n_d;
      wr_n_q              <= wr_n_d;
      hbe_n_q             <= hbe_n_d;
      req_ready_q         <= rdy_d;
      rsp_valid_q         <= vld_d;
      rsp_timeout_q       <= tmo_d;
      card_side_disable_q <= dis_d;
      cnt_q               <= cnt_d;
      hold_n_s_q          <= bus.hold_off_n;
    end
  end

  assign bus.address_in         = addr_q;
  assign bus.data_host          = wdata_q;
  assign bus.chip_select_n      = cs_n_q;
  assign bus.read_strobe_n      = rd_n_q;
  assign bus.write_strobe_n     = wr_n_q;
  assign bus.high_byte_enable_n = hbe_n_q;
  assign bus.rd_wr_dir          = 1'b1;
  assign bus.bus_status_strap   = 1'b1;
  assign bus.config_straps      = {big_endian_strap, `LSP_BUS_GENERIC};
endmodule

/* File: sim/lsp_bus_sva.sv */
`timescale 1ns/10ps
// ==========================================
// wire protocol checks
module lsp_bus_sva (
  input logic        clk,
  input logic        reset_n,
  input logic [16:0] address_in,
  input logic        data_dev_oe,
  input logic        chip_select_n,
  input logic        read_strobe_n,
  input logic        write_strobe_n,
  input logic        rd_wr_dir,
  input logic        hold_off_n,
  input logic        bus_status_strap,
  input logic [3:0]  config_straps
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  dir_held_high_a: assert property (rd_wr_dir)
    else $error("direction pin not high");
  mode_straps_a: assert property (bus_status_strap && config_straps[2:0] == 3'h7)
    else $error("mode straps wrong");
  straps_stable_a: assert property ($past(reset_n, 3) |-> $stable(config_straps))
    else $error("straps moved after reset");
  one_strobe_a: assert property (read_strobe_n || write_strobe_n)
    else $error("both strobes low");
  oe_on_read_a: assert property ($rose(data_dev_oe) |-> !read_strobe_n && !chip_select_n)
    else $error("data driven without read");
  oe_not_write_a: assert property (data_dev_oe |-> write_strobe_n)
    else $error("data driven during write");
  hold_cause_a: assert property ($fell(hold_off_n) |-> !chip_select_n)
    else $error("hold-off without select");
  hold_taken_a: assert property ($fell(chip_select_n) |-> ##[1:5] !hold_off_n)
    else $error("hold-off not asserted");
  hold_bound_a: assert property (!hold_off_n |-> ##[1:30] hold_off_n)
    else $error("hold-off stuck low");
  cycle_held_a: assert property (!chip_select_n && !hold_off_n |=>
    $stable({chip_select_n, read_strobe_n, write_strobe_n, address_in}))
    else $error("cycle changed during hold-off");
  cycle_ends_a: assert property ($rose(hold_off_n) && !chip_select_n |-> ##[1:4] chip_select_n)
    else $error("cycle not ended");
endmodule

/* File: sim/lcd_ctrl_shared_enable_host_port_tb_top.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module lcd_ctrl_shared_enable_host_port_tb_top;
  import lsp_pkg::*;
  logic        clk = 0, reset_n = 0, req_valid = 0, req_write = 0, req_high_byte = 0;
  logic        big_endian_strap = 0, core_grant = 0;
  logic [25:0] req_addr = '0;
  logic [15:0] req_wdata = '0, core_rdata = '0, rsp_rdata_q, core_wdata_q, s_wd;
  logic        req_ready_q, rsp_valid_q, rsp_timeout_q, card_side_disable_q, core_req_q, core_we_q;
  logic        big_endian_q, shared_enable_mode_q, generic_mode_q, cfg_valid_q, s_we;
  logic [16:0] core_addr_q, s_addr;
  logic [1:0]  core_be_q, s_be;
  logic [3:0]  s_bus;
  lsp_target_t core_target_q, s_tgt;
  logic [15:0] cmem [int];
  logic [15:0] ref_mem [int];
  logic [31:0] seed = 32'h70b4492e;
  int          miscompares = 0, samples_checked = 0, grants = 0;

  always #10 clk = ~clk;
  lsp_bus_if bif ();
  lsp_host #(.TIMEOUT(16'h0010)) lsp_host_inst (.clk(clk), .reset_n(reset_n), .bus(bif),
    .req_valid(req_valid), .req_write(req_write), .req_high_byte(req_high_byte), .req_addr(req_addr),
    .req_wdata(req_wdata), .big_endian_strap(big_endian_strap), .req_ready_q(req_ready_q),
    .rsp_valid_q(rsp_valid_q), .rsp_rdata_q(rsp_rdata_q), .rsp_timeout_q(rsp_timeout_q),
    .card_side_disable_q(card_side_disable_q));
  lsp_device lsp_device_inst (.host_bus_clock(clk), .reset_n(reset_n), .bus(bif), .core_req_q(core_req_q),
    .core_we_q(core_we_q), .core_target_q(core_target_q), .core_addr_q(core_addr_q),
    .core_wdata_q(core_wdata_q), .core_be_q(core_be_q), .core_grant(core_grant), .core_rdata(core_rdata),
    .big_endian_q(big_endian_q), .shared_enable_mode_q(shared_enable_mode_q),
    .generic_mode_q(generic_mode_q), .cfg_valid_q(cfg_valid_q));
  lsp_bus_sva lsp_bus_sva_inst (.clk(clk), .reset_n(reset_n), .address_in(bif.address_in),
    .data_dev_oe(bif.data_dev_oe), .chip_select_n(bif.chip_select_n), .read_strobe_n(bif.read_strobe_n),
    .write_strobe_n(bif.write_strobe_n), .rd_wr_dir(bif.rd_wr_dir), .hold_off_n(bif.hold_off_n),
    .bus_status_strap(bif.bus_status_strap), .config_straps(bif.config_straps));

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic lsp_target_t tgt_of(logic [16:0] a);
    if (a <= 17'h13fff) return LSP_TGT_MEM;
    if (a >= 17'h1ffe0) return LSP_TGT_REG;
    return LSP_TGT_NONE;
  endfunction

  // ==========================================
  // core side: grants after a random stall
  always begin
    @(posedge clk);
    #1;
    if (core_req_q === 1'b1) begin
      repeat (rnd() % 6) begin
        @(posedge clk);
        #1;
      end
      `CHK(bif.hold_off_n, 1'b0)
      {s_tgt, s_addr, s_we, s_be, s_wd} = {core_target_q, core_addr_q, core_we_q, core_be_q, core_wdata_q};
      s_bus = {bif.write_strobe_n, bif.read_strobe_n, bif.high_byte_enable_n, card_side_disable_q};
      core_rdata = cmem.exists(core_addr_q) ? cmem[core_addr_q] : 16'h0000;
      if (core_we_q) cmem[core_addr_q] = {core_be_q[1] ? core_wdata_q[15:8] : core_rdata[15:8], core_wdata_q[7:0]};
      core_grant = 1;
      grants++;
      @(posedge clk);
      #1 core_grant = 0;
      @(posedge clk);
      #1;
      `CHK(bif.hold_off_n, 1'b1)
    end
  end

  // ==========================================
  // host side tasks
  task automatic do_op(input logic w, input logic hi, input logic [25:0] a, input logic [15:0] wd);
    int n = 0;
    int g0 = grants;
    lsp_target_t t = tgt_of(a[16:0]);
    logic [15:0] m = hi ? 16'hffff : 16'h00ff;
    logic [15:0] ex = ref_mem.exists(a[16:0]) ? ref_mem[a[16:0]] : 16'h0000;
    while (req_ready_q !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    {req_valid, req_write, req_high_byte, req_addr, req_wdata} = {1'b1, w, hi, a, wd};
    @(posedge clk);
    #1 req_valid = 0;
    while (rsp_valid_q !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK(rsp_valid_q, 1'b1)
    `CHK(rsp_timeout_q, 1'b0)
    `CHK(grants, (t == LSP_TGT_NONE) ? g0 : g0 + 1)
    if (t != LSP_TGT_NONE) begin
      `CHK({s_tgt, s_addr, s_we, s_be}, {t, a[16:0], w, hi, 1'b1})
      `CHK(s_bus, {!w, w, !hi, 1'b1})
      if (w) `CHK(s_wd & m, (big_endian_strap ? {wd[7:0], wd[15:8]} : wd) & m)
    end
    if (!w) `CHK(rsp_rdata_q, (t == LSP_TGT_NONE) ? 16'h0000 : ex & m)
    else if (t != LSP_TGT_NONE) ref_mem[a[16:0]] = {hi ? wd[15:8] : ex[15:8], wd[7:0]};
  endtask

  task automatic run_phase(input logic be);
    logic [31:0] r;
    logic [16:0] a;
    reset_n = 0;
    big_endian_strap = be;
    ref_mem.delete();
    cmem.delete();
    repeat (6) @(posedge clk);
    #1 reset_n = 1;
    repeat (3) @(posedge clk);
    #1;
    `CHK({big_endian_q, shared_enable_mode_q, generic_mode_q, cfg_valid_q}, {be, 3'b111})
    do_op(1, 1, 26'h0000000, 16'ha55a);
    do_op(1, 1, 26'h0013fff, 16'h1234);
    do_op(1, 1, 26'h003ffff, 16'hbeef);
    do_op(0, 1, 26'h001ffff, 16'h0000);
    do_op(1, 1, 26'h0014000, 16'h7777);
    do_op(0, 1, 26'h0014000, 16'h0000);
    do_op(0, 1, 26'h001ffdf, 16'h0000);
    do_op(0, be, 26'h0213fff, 16'h0000);
    for (int i = 0; i < 30; i++) begin
      r = rnd();
      case (r[2:0])
        3'h0: a = 17'h00000;
        3'h1: a = 17'h13fff;
        3'h2: a = 17'h13fe0 | r[12:8];
        3'h3: a = 17'h1ffe0 | r[14:10];
        3'h4: a = 17'h1ffff;
        3'h5: a = 17'h14000;
        3'h6: a = 17'h1ffdf;
        default: a = 17'h13ff0 | r[13:10];
      endcase
      do_op(r[8], be | r[9], {r[31:23], a}, r[31:16] ^ r[15:0]);
    end
    $display("test endian %0d done", be);
  endtask

  task close_out;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    run_phase(1'b0);
    run_phase(1'b1);
    close_out;
  end
  initial begin
    #400000;
    miscompares++;
    close_out;
  end
endmodule
